// File: rcw_defs.svh
// Purpose: offsets, field positions, reset values and timing figures of the reset/watchdog block
// Assumes: 20 MHz system clock, registers on a classic Wishbone bus
// Notes:   definitions only
`ifndef RCW_DEFS_SVH
`define RCW_DEFS_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define RCW_ADR_W              8
`define RCW_COMP_CTRL_OFS      8'h50
`define RCW_CAUSE_OFS          8'h54
`define RCW_WD_CTRL_OFS        8'h60

// ----------------------------------------------------------------
// reset_cause_reg fields
// ----------------------------------------------------------------
`define RCW_CAUSE_POR_BIT      0
`define RCW_CAUSE_EXT_BIT      1
`define RCW_CAUSE_BOD_BIT      2
`define RCW_CAUSE_WD_BIT       3
`define RCW_CAUSE_TEST_BIT     4
`define RCW_CAUSE_RESET        5'h00

// ----------------------------------------------------------------
// wd_control_reg fields
// ----------------------------------------------------------------
`define RCW_WD_FLAG_BIT        7
`define RCW_WD_IE_BIT          6
`define RCW_WD_PS3_BIT         5
`define RCW_WD_CE_BIT          4
`define RCW_WD_RE_BIT          3
`define RCW_WD_PS_LO_MSB       2
`define RCW_WD_PS_RESET        4'h0
`define RCW_WD_PS_MAX          4'h9
`define RCW_WD_BASE_COUNT      20'h00800
`define RCW_CHANGE_WINDOW_CYC  3'h4

// ----------------------------------------------------------------
// comparator_control_reg fields
// ----------------------------------------------------------------
`define RCW_COMP_BG_BIT        6

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define RCW_CLK_MHZ            20
`define RCW_STARTUP_SHORT_US   4100
`define RCW_STARTUP_LONG_US    65000
`define RCW_STARTUP_XTAL_CYC   1024
`define RCW_BOD_DISABLED       3'h7

`endif

// File: rcw_pkg.sv
// Purpose: types shared by the reset/watchdog block
// Assumes: nothing
// Notes:   numeric constants live in rcw_defs.svh
package rcw_pkg;

	typedef enum logic [1:0]
	{
		RCW_ST_HOLD  = 2'b00,
		RCW_ST_DELAY = 2'b01,
		RCW_ST_RUN   = 2'b10
	} rcw_start_e;

	typedef enum logic [1:0]
	{
		RCW_WD_STOPPED  = 2'b00,
		RCW_WD_IRQ      = 2'b01,
		RCW_WD_RESET    = 2'b10,
		RCW_WD_IRQ_RST  = 2'b11
	} rcw_wd_mode_e;

endpackage

// File: rcw_reset_control_watchdog.sv
// Purpose: reset source combining, start-up delay and enhanced watchdog with Wishbone registers
// Assumes: raw reset sources are asynchronous; watchdog oscillator is far slower than clk_i
// Notes:   io_reset_o and the release chain are set asynchronously by any raw source; everything else is clocked
//
// Operation
// - while reset, registers return to reset values; a start pulse marks reset-vector start
// - io reset asserts asynchronously from any raw reset source, no clock needed
// - after all sources go inactive, internal reset is stretched by a fuse-selected delay
// - test-port reset input holds the system in reset while it is one
// - low reset pin resets without clock unless fused off; delay starts after release
// - supply below power-on level resets at once; delay runs when it recovers
// - enabled brown-out below trigger resets at once; delay runs after recovery
// - watchdog reset is a one-cycle pulse; delay starts at its falling edge
// - bandgap enabled only for brown-out, comparator bandgap select or converter enable
// - watchdog counts its own oscillator and acts at the selected time-out count
// - restart instruction clears the watchdog counter; software must issue it in time
// - time-outs selectable from the shortest to the longest period
// - interrupt mode raises an interrupt request that can wake from sleep
// - system-reset mode resets the system at expiry
// - combined mode interrupts first, then reverts to reset mode once serviced
// - always-on fuse forces reset enable one and interrupt enable zero
// - within four cycles one write with change enable clear may clear enable or prescale
// - watchdog keeps running in every sleep mode
// - watchdog stays enabled after a watchdog-caused reset
// - reset enable reads and acts as one while the watchdog reset flag is set
// - prescale codes 0 to 9 give 2048 to 1048576 oscillator cycles; higher reserved
// - change enable clears itself four cycles after being set
// - each reset source sets its own cause flag; writing zero clears it
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps

`include "rcw_defs.svh"

module rcw_reset_control_watchdog
	import rcw_pkg::*;
#(
	parameter int DLY_W             = 24,
	parameter int STARTUP_SHORT_CYC = `RCW_STARTUP_SHORT_US * `RCW_CLK_MHZ,
	parameter int STARTUP_LONG_CYC  = `RCW_STARTUP_LONG_US * `RCW_CLK_MHZ,
	parameter int STARTUP_XTAL_CYC  = `RCW_STARTUP_XTAL_CYC
)
(
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire logic                   wb_cyc_i,
	input  wire logic                   wb_stb_i,
	input  wire logic                   wb_we_i,
	input  wire logic [`RCW_ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]             wb_sel_i,
	input  wire logic [31:0]            wb_dat_i,
	output logic      [31:0]            wb_dat_o,
	output logic                        wb_ack_o,
	input  wire logic                   power_ok_i,
	input  wire logic                   reset_pin_n_i,
	input  wire logic                   pin_reset_disable_fuse_i,
	input  wire logic                   brownout_low_i,
	input  wire logic [2:0]             brownout_level_fuse_i,
	input  wire logic                   test_port_reset_i,
	input  wire logic [1:0]             startup_time_fuse_i,
	input  wire logic [3:0]             clock_source_fuse_i,
	input  wire logic                   watchdog_always_on_fuse_i,
	input  wire logic                   converter_enable_i,
	input  wire logic                   wd_osc_i,
	input  wire logic                   wd_restart_i,
	input  wire logic                   wd_irq_ack_i,
	output logic                        io_reset_o,
	output logic                        core_reset_o,
	output logic                        reset_vector_start_o,
	output logic                        wd_irq_o,
	output logic                        bandgap_enable_o
);

	// ----------------------------------------------------------------
	// elaboration checks
	// ----------------------------------------------------------------
	if (DLY_W < 2 || DLY_W > 31 || STARTUP_LONG_CYC + STARTUP_XTAL_CYC >= (1 << DLY_W)
		|| STARTUP_SHORT_CYC < 1 || STARTUP_XTAL_CYC < 0)
	begin : g_bad_param
		$error("rcw: start-up counts do not fit the delay counter");
	end

	// ----------------------------------------------------------------
	// raw reset sources
	// ----------------------------------------------------------------
	logic       bod_enabled;
	logic [3:0] src_raw;
	logic       async_src;

	assign bod_enabled = (brownout_level_fuse_i != `RCW_BOD_DISABLED);
	assign src_raw[`RCW_CAUSE_POR_BIT]  = ~power_ok_i;
	assign src_raw[`RCW_CAUSE_EXT_BIT]  = ~reset_pin_n_i & ~pin_reset_disable_fuse_i;
	assign src_raw[`RCW_CAUSE_BOD_BIT]  = bod_enabled & brownout_low_i;
	assign src_raw[3]                   = test_port_reset_i;
	assign async_src = |src_raw;

	// release chain: set at once by any source, released through three flops
	logic [2:0] rel_sync_reg;
	logic       src_held;

	always_ff @(posedge clk_i or posedge async_src)
	begin
		if (async_src)
			rel_sync_reg <= 3'h7;
		else
			rel_sync_reg <= {rel_sync_reg[1:0], 1'b0};
	end

	assign src_held = rel_sync_reg[1] | rel_sync_reg[2];

	// per-source level synchronisers feeding the cause flags
	logic [3:0] src_s1_reg;
	logic [3:0] src_s2_reg;
	logic [3:0] src_s3_reg;
	logic [3:0] src_seen;

	genvar gi;
	for (gi = 0; gi < 4; gi++)
	begin : g_src_sync
		always_ff @(posedge clk_i)
		begin
			if (rst_i)
			begin
				src_s1_reg[gi] <= 1'b0;
				src_s2_reg[gi] <= 1'b0;
				src_s3_reg[gi] <= 1'b0;
			end
			else
			begin
				src_s1_reg[gi] <= src_raw[gi];
				src_s2_reg[gi] <= src_s1_reg[gi];
				src_s3_reg[gi] <= src_s2_reg[gi];
			end
		end
		assign src_seen[gi] = src_s2_reg[gi] & src_s3_reg[gi];
	end

	// ----------------------------------------------------------------
	// io reset: asynchronous set, no clock needed to assert
	// ----------------------------------------------------------------
	logic core_reset_reg;

	always_ff @(posedge clk_i or posedge async_src)
	begin
		if (async_src)
			io_reset_o <= 1'b1;
		else if (rst_i)
			io_reset_o <= 1'b1;
		else
			io_reset_o <= core_reset_reg;
	end

	// ----------------------------------------------------------------
	// start-up sequencer
	// ----------------------------------------------------------------
	rcw_start_e       start_reg;
	logic [DLY_W-1:0] dly_reg;
	logic [DLY_W-1:0] dly_sel;
	logic             wd_pulse_reg;
	logic             held;

	assign held = src_held | wd_pulse_reg;

	always_comb
	begin
		unique case (startup_time_fuse_i)
			2'h0:    dly_sel = DLY_W'(1);
			2'h1:    dly_sel = DLY_W'(STARTUP_SHORT_CYC);
			default: dly_sel = DLY_W'(STARTUP_LONG_CYC);
		endcase
		if (clock_source_fuse_i[3])
			dly_sel = dly_sel + DLY_W'(STARTUP_XTAL_CYC);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			start_reg            <= RCW_ST_HOLD;
			dly_reg              <= '0;
			core_reset_reg       <= 1'b1;
			reset_vector_start_o <= 1'b0;
		end
		else
		begin
			reset_vector_start_o <= 1'b0;
			unique case (start_reg)
				RCW_ST_HOLD:
				begin
					core_reset_reg <= 1'b1;
					if (!held)
					begin
						// counting begins once the last source, or the wd pulse, falls
						start_reg <= RCW_ST_DELAY;
						dly_reg   <= dly_sel - DLY_W'(1);
					end
				end
				RCW_ST_DELAY:
				begin
					if (held)
						start_reg <= RCW_ST_HOLD;
					else if (dly_reg == '0)
					begin
						start_reg            <= RCW_ST_RUN;
						core_reset_reg       <= 1'b0;
						reset_vector_start_o <= 1'b1;
					end
					else
						dly_reg <= dly_reg - DLY_W'(1);
				end
				RCW_ST_RUN:
				begin
					if (held)
					begin
						start_reg      <= RCW_ST_HOLD;
						core_reset_reg <= 1'b1;
					end
				end
				default:
				begin
					start_reg      <= RCW_ST_HOLD;
					core_reset_reg <= 1'b1;
				end
			endcase
		end
	end

	assign core_reset_o = core_reset_reg;

	// ----------------------------------------------------------------
	// wishbone slave: ack one cycle after the strobe, write at the ack edge
	// ----------------------------------------------------------------
	logic       bus_wr;
	logic       regs_rst;
	logic [7:0] rd_mux;

	assign bus_wr   = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign regs_rst = rst_i | core_reset_reg;

	// ----------------------------------------------------------------
	// watchdog control register
	// ----------------------------------------------------------------
	logic         wd_ie_reg;
	logic         wd_re_reg;
	logic [3:0]   wd_ps_reg;
	logic [2:0]   win_reg;
	logic         wd_flag_reg;
	logic         cause_wd_reg;
	logic         wd_wr;
	logic         wr_ce;
	logic         wr_re;
	logic         wd_re_eff;
	logic         wd_ie_eff;
	rcw_wd_mode_e wd_mode;

	assign wd_wr     = bus_wr & (wb_adr_i == `RCW_WD_CTRL_OFS);
	assign wr_ce     = wb_dat_i[`RCW_WD_CE_BIT];
	assign wr_re     = wb_dat_i[`RCW_WD_RE_BIT];
	assign wd_re_eff = wd_re_reg | cause_wd_reg | watchdog_always_on_fuse_i;
	assign wd_ie_eff = wd_ie_reg & ~watchdog_always_on_fuse_i;
	assign wd_mode   = rcw_wd_mode_e'({wd_re_eff, wd_ie_eff});

	always_ff @(posedge clk_i)
	begin
		if (regs_rst)
		begin
			wd_ie_reg <= 1'b0;
			wd_re_reg <= 1'b0;
			wd_ps_reg <= `RCW_WD_PS_RESET;
			win_reg   <= '0;
		end
		else
		begin
			if (win_reg != '0)
				win_reg <= win_reg - 3'h1;
			if (wd_wr)
			begin
				wd_ie_reg <= wb_dat_i[`RCW_WD_IE_BIT];
				if (wr_ce && wr_re)
					win_reg <= `RCW_CHANGE_WINDOW_CYC;
				if (wr_re)
					wd_re_reg <= 1'b1;
				else if (win_reg != '0 && !wr_ce)
					wd_re_reg <= 1'b0;
				if (win_reg != '0 && !wr_ce)
				begin
					wd_ps_reg <= {wb_dat_i[`RCW_WD_PS3_BIT],
						wb_dat_i[`RCW_WD_PS_LO_MSB:0]};
					win_reg   <= '0;
				end
			end
			// vector taken in combined mode: fall back to plain reset mode
			if (wd_irq_ack_i && wd_mode == RCW_WD_IRQ_RST)
				wd_ie_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// watchdog oscillator edge and counter
	// ----------------------------------------------------------------
	logic [2:0]  osc_sync_reg;
	logic        osc_lvl_reg;
	logic        osc_tick;
	logic [19:0] wd_cnt_reg;
	logic [19:0] wd_limit;
	logic [3:0]  ps_used;
	logic        wd_run;
	logic        wd_timeout;
	logic        do_reset;
	logic        do_irq;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			osc_sync_reg <= '0;
			osc_lvl_reg  <= 1'b0;
		end
		else
		begin
			osc_sync_reg <= {osc_sync_reg[1:0], wd_osc_i};
			if (osc_sync_reg[1] == osc_sync_reg[2])
				osc_lvl_reg <= osc_sync_reg[2];
		end
	end

	assign osc_tick = osc_sync_reg[1] & osc_sync_reg[2] & ~osc_lvl_reg;
	// reserved codes run at the longest period rather than an undefined one
	assign ps_used  = (wd_ps_reg > `RCW_WD_PS_MAX) ? `RCW_WD_PS_MAX : wd_ps_reg;
	assign wd_limit = (`RCW_WD_BASE_COUNT << ps_used) - 20'h00001;
	// no sleep input: only the stopped mode or a register reset stops the counter
	assign wd_run   = (wd_mode != RCW_WD_STOPPED);
	assign wd_timeout = wd_run & osc_tick & (wd_cnt_reg == wd_limit);
	// in combined mode an unserviced flag turns the next expiry into a reset
	assign do_reset = wd_timeout & wd_re_eff & (~wd_ie_eff | wd_flag_reg);
	assign do_irq   = wd_timeout & wd_ie_eff & ~do_reset;

	always_ff @(posedge clk_i)
	begin
		if (regs_rst || !wd_run || wd_restart_i)
			wd_cnt_reg <= '0;
		else if (osc_tick)
			wd_cnt_reg <= wd_timeout ? 20'h00000 : wd_cnt_reg + 20'h00001;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wd_pulse_reg <= 1'b0;
		else
			wd_pulse_reg <= do_reset & ~wd_pulse_reg;
	end

	always_ff @(posedge clk_i)
	begin
		if (regs_rst)
			wd_flag_reg <= 1'b0;
		else if (do_irq)
			wd_flag_reg <= 1'b1;
		else if ((wd_wr && wb_dat_i[`RCW_WD_FLAG_BIT]) ||
			(wd_irq_ack_i && wd_ie_eff))
			wd_flag_reg <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (regs_rst)
			wd_irq_o <= 1'b0;
		else
			wd_irq_o <= wd_flag_reg & wd_ie_eff;
	end

	// ----------------------------------------------------------------
	// reset cause flags: survive internal reset, cleared by power-on
	// ----------------------------------------------------------------
	logic [4:0] cause_reg;
	logic       cause_wr;

	assign cause_wr     = bus_wr & (wb_adr_i == `RCW_CAUSE_OFS);
	assign cause_wd_reg = cause_reg[`RCW_CAUSE_WD_BIT];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			cause_reg <= `RCW_CAUSE_RESET;
		else
		begin
			// set wins over a software clear landing in the same cycle
			cause_reg <= (cause_wr ? (cause_reg & wb_dat_i[4:0]) : cause_reg)
				| {src_seen[3], wd_pulse_reg, src_seen[2:0]};
			if (src_seen[`RCW_CAUSE_POR_BIT])
				cause_reg[4:1] <= 4'h0;
		end
	end

	// ----------------------------------------------------------------
	// comparator control and bandgap enable
	// ----------------------------------------------------------------
	logic comp_bg_reg;

	always_ff @(posedge clk_i)
	begin
		if (regs_rst)
			comp_bg_reg <= 1'b0;
		else if (bus_wr && wb_adr_i == `RCW_COMP_CTRL_OFS)
			comp_bg_reg <= wb_dat_i[`RCW_COMP_BG_BIT];
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bandgap_enable_o <= 1'b0;
		else
			bandgap_enable_o <= bod_enabled | comp_bg_reg | converter_enable_i;
	end

	// ----------------------------------------------------------------
	// read mux and bus answer
	// ----------------------------------------------------------------
	always_comb
	begin
		unique case (wb_adr_i)
			`RCW_CAUSE_OFS:     rd_mux = {3'h0, cause_reg};
			`RCW_WD_CTRL_OFS:   rd_mux = {wd_flag_reg, wd_ie_eff, wd_ps_reg[3], win_reg != '0,
				wd_re_eff, wd_ps_reg[2:0]};
			`RCW_COMP_CTRL_OFS: rd_mux = {1'b0, comp_bg_reg, 6'h00};
			default:            rd_mux = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= '0;
		end
		else
		begin
			wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
			wb_dat_o <= (wb_cyc_i & wb_stb_i & ~wb_ack_o) ? {24'h000000, rd_mux} : 32'h00000000;
		end
	end

endmodule

// File: rcw_reset_control_watchdog_properties.sv
// Purpose: port-level checks of the reset/watchdog block
// Assumes: one system clock; raw reset sources change just after clock edges
// Notes:   bound into the block at the foot of this file
`timescale 1ns/1ps
`include "rcw_defs.svh"
module rcw_props
(
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       power_ok_i,
	input wire logic       reset_pin_n_i,
	input wire logic       pin_reset_disable_fuse_i,
	input wire logic       brownout_low_i,
	input wire logic [2:0] brownout_level_fuse_i,
	input wire logic       test_port_reset_i,
	input wire logic       watchdog_always_on_fuse_i,
	input wire logic       converter_enable_i,
	input wire logic       wd_irq_ack_i,
	input wire logic       io_reset_o,
	input wire logic       core_reset_o,
	input wire logic       reset_vector_start_o,
	input wire logic       wd_irq_o,
	input wire logic       bandgap_enable_o
);
	logic bod_on;
	logic src;
	assign bod_on = brownout_level_fuse_i != `RCW_BOD_DISABLED;
	assign src = !power_ok_i | test_port_reset_i | (!reset_pin_n_i & !pin_reset_disable_fuse_i)
		| (brownout_low_i & bod_on);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// ----------------------------------------------------------------
	// steps
	// ----------------------------------------------------------------
	// a rise with no source nearby can only be the watchdog pulse
	sequence s_quiet_rise;
		!src [*3] ##1 $rose(core_reset_o);
	endsequence
	sequence s_vector_pulse;
		reset_vector_start_o ##1 !reset_vector_start_o;
	endsequence

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_io_follows_src: assert property (src |-> io_reset_o)
		else $error("io reset low while a source is active");
	a_core_held_src: assert property (src [*6] |-> core_reset_o)
		else $error("core reset low under a held source");
	a_rst_clears_all: assert property (disable iff (1'b0) rst_i |=> core_reset_o
		&& io_reset_o && !wd_irq_o && !reset_vector_start_o)
		else $error("block reset did not clear outputs");
	a_vector_on_fall: assert property ($fell(core_reset_o) |-> s_vector_pulse)
		else $error("start pulse missing or too long");
	a_delay_after_src: assert property ($fell(core_reset_o) |-> !$past(src, 1)
		&& !$past(src, 2) && !$past(src, 3))
		else $error("core reset released too soon after a source");
	a_wd_reset_stretch: assert property (s_quiet_rise |=> core_reset_o)
		else $error("watchdog reset not stretched");
	a_ack_clears_irq: assert property (wd_irq_ack_i |-> ##[1:2] !wd_irq_o)
		else $error("interrupt request stays after service");
	a_fuse_no_irq: assert property (watchdog_always_on_fuse_i [*3] |-> !wd_irq_o)
		else $error("interrupt raised with always-on fuse");
	a_bandgap_needed: assert property (((bod_on || converter_enable_i) && !core_reset_o) [*2]
		|-> bandgap_enable_o)
		else $error("bandgap off while requested");
endmodule

bind rcw_reset_control_watchdog rcw_props rcw_props_inst (.clk_i(clk_i), .rst_i(rst_i),
	.power_ok_i(power_ok_i), .reset_pin_n_i(reset_pin_n_i),
	.pin_reset_disable_fuse_i(pin_reset_disable_fuse_i), .brownout_low_i(brownout_low_i),
	.brownout_level_fuse_i(brownout_level_fuse_i), .test_port_reset_i(test_port_reset_i),
	.watchdog_always_on_fuse_i(watchdog_always_on_fuse_i),
	.converter_enable_i(converter_enable_i), .wd_irq_ack_i(wd_irq_ack_i),
	.io_reset_o(io_reset_o), .core_reset_o(core_reset_o),
	.reset_vector_start_o(reset_vector_start_o), .wd_irq_o(wd_irq_o),
	.bandgap_enable_o(bandgap_enable_o));

// File: rcw_core_model.sv
// Purpose: processor-side model driving the register bus and watchdog strobes
// Assumes: classic Wishbone single cycles, one at a time
// Notes:   tasks are called from the bench by hierarchical name
`timescale 1ns/1ps
`include "rcw_defs.svh"
module rcw_core_model
(
	input  wire logic        clk_i,
	input  wire logic        wb_ack_i,
	input  wire logic [31:0] wb_dat_i,
	output logic             wb_cyc_o,
	output logic             wb_stb_o,
	output logic             wb_we_o,
	output logic [7:0]       wb_adr_o,
	output logic [3:0]       wb_sel_o,
	output logic [31:0]      wb_dat_o,
	output logic             wd_restart_o,
	output logic             wd_irq_ack_o
);
	initial
	begin
		{wb_cyc_o, wb_stb_o, wb_we_o, wd_restart_o, wd_irq_ack_o} = 5'h00;
		wb_adr_o = 8'h00;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h0;
	end

	task automatic xfer(input logic we, input logic [7:0] adr, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		{wb_cyc_o, wb_stb_o, wb_we_o} <= {2'b11, we};
		wb_adr_o <= adr;
		wb_sel_o <= 4'h1;
		wb_dat_o <= {24'h0, d};
		do
			@(posedge clk_i);
		while (wb_ack_i !== 1'b1);
		q = wb_dat_i;
		{wb_cyc_o, wb_stb_o} <= 2'b00;
		// released lines carry junk so stale values are never trusted
		wb_adr_o <= ~adr;
		wb_sel_o <= 4'he;
		wb_dat_o <= ~{24'h0, d};
	endtask

	task automatic strobe(input logic irq);
		@(posedge clk_i);
		if (irq)
			wd_irq_ack_o <= 1'b1;
		else
			wd_restart_o <= 1'b1;
		@(posedge clk_i);
		{wd_irq_ack_o, wd_restart_o} <= 2'b00;
	endtask

	// restart first: a shorter period could otherwise expire at once
	task automatic unlock(input logic [7:0] v);
		logic [31:0] q;
		strobe(1'b0);
		xfer(1'b1, `RCW_WD_CTRL_OFS, 8'h18, q);
		xfer(1'b1, `RCW_WD_CTRL_OFS, v, q);
	endtask
endmodule

// File: tb.sv
// Purpose: self-checking bench for the reset/watchdog block
// Assumes: start-up delays shortened to 8/16/4 cycles; watchdog oscillator is clk/6
// Notes:   expectations come from a small integer model of the registers
`timescale 1ns/1ps
`include "rcw_defs.svh"
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
	$display("wrong value at %0t: got %h, expected %h", $time, a, e); end end
module tb;
	localparam logic [7:0] CT = `RCW_WD_CTRL_OFS;
	localparam logic [7:0] CA = `RCW_CAUSE_OFS;
	logic        clk_i, rst_i, power_ok_i, reset_pin_n_i, pin_reset_disable_fuse_i;
	logic        brownout_low_i, test_port_reset_i, watchdog_always_on_fuse_i;
	logic        converter_enable_i, wd_osc_i, wd_restart_i, wd_irq_ack_i;
	logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, io_reset_o, core_reset_o;
	logic        reset_vector_start_o, wd_irq_o, bandgap_enable_o;
	logic [2:0]  brownout_level_fuse_i;
	logic [1:0]  startup_time_fuse_i;
	logic [3:0]  clock_source_fuse_i, wb_sel_i;
	logic [7:0]  wb_adr_i;
	logic [31:0] wb_dat_i, wb_dat_o, r;
	int          miscompares = 0, cmp_count = 0, seed = 32'h8ff5;
	int          osc_n = 0, n, div = 0, cause = 0;

	rcw_reset_control_watchdog #(.STARTUP_SHORT_CYC(8), .STARTUP_LONG_CYC(16),
		.STARTUP_XTAL_CYC(4)) rcw_reset_control_watchdog_inst (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.power_ok_i(power_ok_i), .reset_pin_n_i(reset_pin_n_i),
		.pin_reset_disable_fuse_i(pin_reset_disable_fuse_i), .brownout_low_i(brownout_low_i),
		.brownout_level_fuse_i(brownout_level_fuse_i), .test_port_reset_i(test_port_reset_i),
		.startup_time_fuse_i(startup_time_fuse_i), .clock_source_fuse_i(clock_source_fuse_i),
		.watchdog_always_on_fuse_i(watchdog_always_on_fuse_i),
		.converter_enable_i(converter_enable_i), .wd_osc_i(wd_osc_i),
		.wd_restart_i(wd_restart_i), .wd_irq_ack_i(wd_irq_ack_i), .io_reset_o(io_reset_o),
		.core_reset_o(core_reset_o), .reset_vector_start_o(reset_vector_start_o),
		.wd_irq_o(wd_irq_o), .bandgap_enable_o(bandgap_enable_o));
	rcw_core_model core_inst (.clk_i(clk_i), .wb_ack_i(wb_ack_o), .wb_dat_i(wb_dat_o),
		.wb_cyc_o(wb_cyc_i), .wb_stb_o(wb_stb_i), .wb_we_o(wb_we_i), .wb_adr_o(wb_adr_i),
		.wb_sel_o(wb_sel_i), .wb_dat_o(wb_dat_i), .wd_restart_o(wd_restart_i),
		.wd_irq_ack_o(wd_irq_ack_i));

	initial
	begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		div <= (div == 2) ? 0 : div + 1;
		if (div == 2)
			wd_osc_i <= ~wd_osc_i;
	end
	always @(posedge wd_osc_i)
		osc_n++;

	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		core_inst.xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [31:0] q;
		core_inst.xfer(1'b0, a, 8'h00, q);
		`CHK(q, {24'h0, e})
	endtask
	task automatic wait_lvl(input logic core, input logic lvl);
		n = 0;
		while (((core ? core_reset_o : wd_irq_o) !== lvl) && n < 20000)
		begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task automatic restart();
		core_inst.strobe(1'b0);
		osc_n = 0;
	endtask
	// source s with its own start-up setting; delay in cycles of the shortened table
	task automatic src_hit(input int s);
		int d;
		d = (s == 1) ? 8 : (s == 2) ? 16 : (s == 3) ? 5 : 1;
		r = $random(seed);
		@(posedge clk_i);
		startup_time_fuse_i <= 2'(s % 3);
		// only bit 3 lengthens the delay; the low bits must not matter
		clock_source_fuse_i <= {s == 3, r[2:0]};
		case (s)
			0: power_ok_i <= 1'b0;
			1: reset_pin_n_i <= 1'b0;
			2: brownout_low_i <= 1'b1;
			default: test_port_reset_i <= 1'b1;
		endcase
		#1 `CHK(io_reset_o, 1'b1)
		repeat (10) @(posedge clk_i);
		`CHK(core_reset_o, 1'b1)
		{power_ok_i, reset_pin_n_i, brownout_low_i, test_port_reset_i} <= 4'b1100;
		wait_lvl(1'b1, 1'b0);
		`CHK(n >= d + 2 && n <= d + 7, 1'b1)
		cause = (s == 0) ? 1 : cause | (1 << ((s == 3) ? 4 : s));
		rd(CA, 8'(cause));
	endtask

	initial
	begin
		{rst_i, power_ok_i, reset_pin_n_i, pin_reset_disable_fuse_i} = 4'b1110;
		{brownout_low_i, test_port_reset_i, watchdog_always_on_fuse_i} = 3'b000;
		{converter_enable_i, wd_osc_i} = 2'b00;
		brownout_level_fuse_i = 3'h4;
		startup_time_fuse_i = 2'h0;
		clock_source_fuse_i = 4'h0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		wait_lvl(1'b1, 1'b0);
		rd(CT, 8'h00);
		rd(CA, `RCW_CAUSE_RESET);
		rd(8'h70, 8'h00);
		for (int s = 0; s < 4; s++)
			src_hit(s);
		@(posedge clk_i);
		{pin_reset_disable_fuse_i, reset_pin_n_i} <= 2'b10;
		repeat (8) @(posedge clk_i);
		`CHK({io_reset_o, core_reset_o}, 2'b00)
		{pin_reset_disable_fuse_i, reset_pin_n_i} <= 2'b01;
		wr(CA, 8'h00);
		rd(CA, 8'h00);
		for (int i = 0; i < 6; i++)
		begin
			r = $random(seed);
			@(posedge clk_i);
			converter_enable_i <= r[0];
			brownout_level_fuse_i <= r[1] ? `RCW_BOD_DISABLED : 3'h4;
			{pin_reset_disable_fuse_i, watchdog_always_on_fuse_i} <= r[4:3];
			startup_time_fuse_i <= r[6:5];
			wr(`RCW_COMP_CTRL_OFS, {1'b0, r[2], 6'h00});
			repeat (3) @(posedge clk_i);
			`CHK(bandgap_enable_o, r[0] | r[2] | !r[1])
			rd(CT, {4'h0, r[3], 3'h0});
		end
		watchdog_always_on_fuse_i <= 1'b0;
		// outside the window only the reset and interrupt enables can be set
		wr(CT, 8'h0f);
		rd(CT, 8'h08);
		wr(CT, 8'h00);
		rd(CT, 8'h08);
		wr(CT, 8'h18);
		repeat (6) @(posedge clk_i);
		wr(CT, 8'h00);
		rd(CT, 8'h08);
		core_inst.unlock(8'h00);
		rd(CT, 8'h00);
		wr(CT, 8'h40);
		restart();
		wait_lvl(1'b0, 1'b1);
		`CHK(osc_n >= 2047 && osc_n <= 2050, 1'b1)
		rd(CT, 8'hc0);
		core_inst.strobe(1'b1);
		repeat (2) @(posedge clk_i);
		`CHK(wd_irq_o, 1'b0)
		rd(CT, 8'h40);
		wr(CT, 8'h48);
		restart();
		wait_lvl(1'b0, 1'b1);
		`CHK(osc_n >= 2047 && osc_n <= 2050, 1'b1)
		core_inst.strobe(1'b1);
		rd(CT, 8'h08);
		while (osc_n < 3000)
			@(posedge clk_i);
		restart();
		wait_lvl(1'b1, 1'b1);
		`CHK(osc_n >= 2047 && osc_n <= 2050, 1'b1)
		wait_lvl(1'b1, 1'b0);
		rd(CA, 8'h08);
		rd(CT, 8'h08);
		core_inst.unlock(8'h00);
		rd(CT, 8'h08);
		wr(CA, 8'h00);
		core_inst.unlock(8'h00);
		rd(CT, 8'h00);
		@(posedge clk_i);
		watchdog_always_on_fuse_i <= 1'b1;
		wr(CT, 8'h40);
		rd(CT, 8'h08);
		report_and_stop();
	end

	// the whole sequence needs about 43000 cycles
	initial
	begin
		repeat (80000) @(posedge clk_i);
		miscompares++;
		report_and_stop();
	end
endmodule
